/* File: hdl/gpc_pkg.sv */
// constants and types of the gated pulse counter
package gpc_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_CMP = 6'h10;
	localparam logic [5:0] IDX_GATE = 6'h11;
	localparam logic [5:0] IDX_CFG = 6'h12;
	localparam logic [5:0] IDX_CTRL1 = 6'h14;
	localparam logic [5:0] IDX_CTRL2 = 6'h15;
	localparam logic [5:0] IDX_STAT = 6'h16;

	localparam logic [7:0] CTRL1_RST = 8'h88;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] GATE_RST = 8'h00;
	localparam logic [1:0] CFG_RST = 2'h0;
	localparam logic [17:0] CMP_RST = 18'h3ffff;
	localparam logic [17:0] CNT_MAX = 18'h3ffff;

	// control one fields
	localparam int C1_CLR = 7;
	localparam int C1_RUN = 5;
	localparam int C1_SRC = 2;
	localparam int C1_MODE = 0;
	// control two fields
	localparam int C2_SEG = 7;
	localparam int C2_SGP = 5;
	localparam int C2_GATE_IRQ_EDGE_SELECT = 4;
	localparam int C2_WPS = 2;
	localparam int C2_AUXG = 1;
	// status fields
	localparam int ST_ACT = 7;
	localparam int ST_OVF = 6;
	// configuration fields
	localparam int CFG_DV = 0;
	localparam int CFG_SLOW = 1;
	// gate setting fields
	localparam int GS_TA = 0;
	localparam int GS_TB = 4;

	localparam logic [1:0] RUN_STOP = 2'h0;
	localparam logic [1:0] RUN_START = 2'h2;
	localparam logic [1:0] MODE_TE = 2'h0;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_FREQ = 2'h3;
	localparam logic [2:0] SRC_FC = 3'h0;
	localparam logic [2:0] SRC_FS = 3'h1;
	localparam logic [2:0] SRC_D2 = 3'h2;
	localparam logic [2:0] SRC_D3 = 3'h3;
	localparam logic [2:0] SRC_D4 = 3'h4;
	localparam logic [2:0] SRC_D5 = 3'h5;
	localparam logic [2:0] SRC_D6 = 3'h6;
	localparam logic [2:0] SRC_EXT = 3'h7;
	localparam logic [1:0] GSRC_PIN = 2'h0;
	localparam logic [1:0] GSRC_INT = 2'h1;
	localparam logic [1:0] GSRC_AUX = 2'h2;
	localparam logic [1:0] WPS_RSV = 2'h3;

	// divider taps, as powers of two of the divided clock
	localparam int TAP_FC2 = 23;
	localparam int TAP_FC3 = 13;
	localparam int TAP_FC4 = 11;
	localparam int TAP_FC5 = 7;
	localparam int TAP_FC6 = 3;
	localparam int TAP_FS2 = 15;
	localparam int TAP_FS3 = 5;
	localparam int TAP_FS4 = 3;
	localparam int GTAP_FC = 12;
	localparam int GTAP_FS = 4;
	localparam int FAST_CMP_LO = 11;
	localparam logic [4:0] GATE_LEN = 5'h10;

	// synchroniser lanes
	localparam int SY_ECI = 0;
	localparam int SY_EGI = 1;
	localparam int SY_FS = 2;
	localparam int SY_N = 3;

	typedef enum logic [1:0] {
		GPC_GATE_HIGH = 2'h1,
		GPC_GATE_LOW = 2'h2
	} gpc_gate_type;
endpackage

/* File: hdl/gpc_sync.sv */
// two-stage synchroniser with edge detection
`timescale 1ns/100ps
`default_nettype none
module gpc_sync
(
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic din, // raw input
	output logic lvl, // synchronised level
	output logic rise, // one-cycle rising pulse
	output logic fall // one-cycle falling pulse
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} gpc_sync_type;

	gpc_sync_type st;
	gpc_sync_type next_st;

	always_comb
	begin
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign lvl = st.s2;
	assign rise = st.s2 & ~st.s3;
	assign fall = ~st.s2 & st.s3;

	a_sync_delay: assert property (@(posedge clk) disable iff (!rst_n)
		##3 (lvl == $past(din, 2)))
		else $error("synchroniser latency is not two cycles");
endmodule
`default_nettype wire

/* File: hdl/gpc_top.sv */
// gated 18-bit pulse counter with apb register slave
`timescale 1ns/100ps
`default_nettype none
module gpc_top
	import gpc_pkg::*;
(
	input wire logic pclk, // system clock, 20 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error
	input wire logic external_count_input, // count pin
	input wire logic external_gate_input, // gate pin
	input wire logic fs_clock_level, // low-frequency clock level
	input wire logic aux_timer_output, // aux eight-bit timer output
	output logic aux_pin_out, // aux pin data
	output logic aux_pin_drive, // aux pin driven when high
	output logic counter_interrupt // interrupt request pulse
);
	typedef struct packed {
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [7:0] gate_set;
		logic [1:0] cfg;
		logic [17:0] cmp;
		logic [17:0] cnt;
		logic ovf;
		logic [22:0] fc_div;
		logic [14:0] fs_div;
		gpc_gate_type gph;
		logic [4:0] gcnt;
		logic gate_q;
		logic and_q;
		logic fand_q;
		logic irq;
		logic [31:0] rdata;
		logic slverr;
		logic aux_out;
		logic aux_drv;
	} gpc_state_type;

	gpc_state_type st;
	gpc_state_type next_st;

	logic [SY_N-1:0] sy_din;
	logic [SY_N-1:0] sy_lvl;
	logic [SY_N-1:0] sy_rise;
	logic [SY_N-1:0] sy_fall;

	assign sy_din = {fs_clock_level, external_gate_input,
		external_count_input};

	genvar gi;
	generate
		for (gi = 0; gi < SY_N; gi++)
		begin : g_sync
			gpc_sync u_sync (
				.clk(pclk),
				.rst_n(presetn),
				.din(sy_din[gi]),
				.lvl(sy_lvl[gi]),
				.rise(sy_rise[gi]),
				.fall(sy_fall[gi])
			);
		end
	endgenerate

	function automatic logic [1:0] fc_tap(input logic [22:0] d,
		input int k);
		logic [22:0] m;
		m = 23'((24'h1 << k) - 24'h1);
		fc_tap = {d[k-1], (d & m) == m};
	endfunction

	function automatic logic [1:0] fs_tap(input logic [14:0] d,
		input int k, input logic f);
		logic [14:0] m;
		m = 15'((16'h1 << k) - 16'h1);
		fs_tap = {d[k-1], f && ((d & m) == m)};
	endfunction

	function automatic logic [31:0] gpc_merge(input logic [31:0] o,
		input logic [31:0] w, input logic [3:0] s);
		for (int b = 0; b < 4; b++)
			if (s[b])
				o[b*8 +: 8] = w[b*8 +: 8];
		gpc_merge = o;
	endfunction

	logic running;
	logic [1:0] mode;
	logic [2:0] src;
	logic alt;
	logic [1:0] tap;
	logic [1:0] gtap;
	logic gtick;
	logic gate;
	logic gen_en;
	logic act;
	logic and_now;
	logic fand_now;
	logic cnt_tick;
	logic match;
	logic [17:0] cplus;
	logic hit;
	logic setup;
	logic wr;
	logic wr_c1;
	logic clear_req;
	logic [31:0] mw;
	logic [4:0] lim;
	logic [4:0] gnext;

	assign running = st.ctrl1[C1_RUN +: 2] == RUN_START;
	assign mode = st.ctrl1[C1_MODE +: 2];
	assign src = st.ctrl1[C1_SRC +: 3];
	assign alt = st.cfg[CFG_DV] | st.cfg[CFG_SLOW];
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite & hit;
	assign wr_c1 = wr && paddr[7:2] == IDX_CTRL1 && pstrb[0];
	assign clear_req = wr_c1 && !pwdata[C1_CLR];

	// fc divided by one toggles each cycle, so the fastest source
	// clock seen by the counter is half the system clock
	always_comb
	begin
		case (src)
			SRC_FC: tap = fc_tap(st.fc_div, 1);
			SRC_FS: tap = {sy_lvl[SY_FS], sy_fall[SY_FS]};
			SRC_D2: tap = alt ? fs_tap(st.fs_div, TAP_FS2, sy_fall[SY_FS])
				: fc_tap(st.fc_div, TAP_FC2);
			SRC_D3: tap = alt ? fs_tap(st.fs_div, TAP_FS3, sy_fall[SY_FS])
				: fc_tap(st.fc_div, TAP_FC3);
			SRC_D4: tap = alt ? fs_tap(st.fs_div, TAP_FS4, sy_fall[SY_FS])
				: fc_tap(st.fc_div, TAP_FC4);
			SRC_D5: tap = fc_tap(st.fc_div, TAP_FC5);
			SRC_D6: tap = fc_tap(st.fc_div, TAP_FC6);
			default: tap = 2'h0;
		endcase
	end

	always_comb
	begin
		gtap = 2'h0;
		if (st.ctrl2[C2_WPS +: 2] != WPS_RSV)
		begin
			if (alt)
				gtap = fs_tap(st.fs_div,
					GTAP_FS + int'(st.ctrl2[C2_WPS +: 2]), sy_fall[SY_FS]);
			else
				gtap = fc_tap(st.fc_div,
					GTAP_FC + int'(st.ctrl2[C2_WPS +: 2]));
		end
		gtick = gtap[0];
	end

	assign gen_en = running && mode == MODE_FREQ &&
		st.ctrl2[C2_SGP +: 2] == GSRC_INT;

	always_comb
	begin
		case (st.ctrl2[C2_SGP +: 2])
			GSRC_PIN: gate = sy_lvl[SY_EGI];
			GSRC_INT: gate = gen_en && st.gph == GPC_GATE_HIGH;
			GSRC_AUX: gate = aux_timer_output;
			default: gate = 1'b0;
		endcase
	end

	assign act = running && mode == MODE_FREQ && gate;
	assign and_now = tap[1] & sy_lvl[SY_ECI];
	assign fand_now = gate & sy_lvl[SY_ECI];
	assign cplus = st.cnt + 18'h1;

	always_comb
	begin
		case (mode)
			MODE_TE:
				if (src == SRC_EXT)
					cnt_tick = sy_fall[SY_ECI] ||
						(st.ctrl2[C2_SEG] && sy_rise[SY_ECI]);
				else
					cnt_tick = tap[0];
			MODE_PWM: cnt_tick = st.and_q & ~and_now;
			MODE_FREQ:
				if (st.ctrl2[C2_SEG])
					cnt_tick = gate & (sy_rise[SY_ECI] | sy_fall[SY_ECI]);
				else
					cnt_tick = st.fand_q & ~fand_now;
			default: cnt_tick = 1'b0;
		endcase
		if (st.cfg[CFG_SLOW] && src == SRC_FC)
			match = cplus[17:FAST_CMP_LO] == st.cmp[17:FAST_CMP_LO];
		else
			match = cplus == st.cmp;
	end

	always_comb
	begin
		case (paddr[7:2])
			IDX_CMP, IDX_GATE, IDX_CFG, IDX_CTRL1, IDX_CTRL2, IDX_STAT:
				hit = paddr[1:0] == 2'h0;
			default: hit = 1'b0;
		endcase
	end

	always_comb
	begin
		next_st = st;
		mw = 32'h0;
		lim = 5'h0;
		gnext = st.gcnt + 5'h1;
		next_st.fc_div = st.fc_div + 23'h1;
		if (sy_fall[SY_FS])
			next_st.fs_div = st.fs_div + 15'h1;
		next_st.irq = 1'b0;
		next_st.aux_out = aux_timer_output & ~st.ctrl2[C2_AUXG];
		next_st.aux_drv = ~st.ctrl2[C2_AUXG];
		next_st.gate_q = gate;
		next_st.and_q = and_now;
		next_st.fand_q = fand_now;

		if (setup)
		begin
			next_st.slverr = !hit;
			case (paddr[7:2])
				IDX_CMP: next_st.rdata = {14'h0, st.cnt};
				IDX_GATE: next_st.rdata = {24'h0, st.gate_set};
				IDX_CFG: next_st.rdata = {30'h0, st.cfg};
				IDX_CTRL1: next_st.rdata = {24'h0, 1'b1, st.ctrl1[6:0]};
				IDX_CTRL2: next_st.rdata = {24'h0, st.ctrl2[7:1], 1'b0};
				IDX_STAT: next_st.rdata = {24'h0, act, st.ovf, 6'h0};
				default: next_st.rdata = 32'h0;
			endcase
			// refused addresses must not leak the live counter
			if (!hit)
				next_st.rdata = 32'h0;
		end

		// counting; holding the value between ticks lets it resume
		if (running && cnt_tick)
		begin
			if (mode == MODE_TE && match)
			begin
				next_st.cnt = 18'h0;
				next_st.irq = 1'b1;
			end
			else
				next_st.cnt = cplus;
		end
		if (!running || clear_req)
			next_st.cnt = 18'h0;
		// a wrap in the clearing cycle still leaves the flag set
		next_st.ovf = (st.ovf & running & ~clear_req) |
			(running & cnt_tick & st.cnt == CNT_MAX);

		if (running && mode == MODE_PWM && (sy_fall[SY_ECI] ||
			(st.ctrl2[C2_GATE_IRQ_EDGE_SELECT] && sy_rise[SY_ECI])))
			next_st.irq = 1'b1;
		if (running && mode == MODE_FREQ && ((st.gate_q && !gate) ||
			(st.ctrl2[C2_GATE_IRQ_EDGE_SELECT] && !st.gate_q && gate)))
			next_st.irq = 1'b1;

		if (wr)
		begin
			case (paddr[7:2])
				IDX_CMP:
				begin
					mw = gpc_merge({14'h0, st.cmp}, pwdata, pstrb);
					next_st.cmp = mw[17:0];
				end
				IDX_GATE:
				begin
					mw = gpc_merge({24'h0, st.gate_set}, pwdata, pstrb);
					next_st.gate_set = mw[7:0];
				end
				IDX_CFG:
				begin
					mw = gpc_merge({30'h0, st.cfg}, pwdata, pstrb);
					next_st.cfg = mw[1:0];
				end
				IDX_CTRL1:
				begin
					mw = gpc_merge({24'h0, st.ctrl1}, pwdata, pstrb);
					next_st.ctrl1 = {1'b1, mw[6:0]};
					if (wr_c1 && mw[C1_MODE +: 2] == MODE_PWM &&
						sy_lvl[SY_ECI])
					begin
						if (running && mw[C1_RUN +: 2] == RUN_STOP)
							next_st.irq = 1'b1;
						if (mw[C1_RUN +: 2] == RUN_START && st.ctrl2[C2_GATE_IRQ_EDGE_SELECT])
							next_st.irq = 1'b1;
					end
				end
				IDX_CTRL2:
				begin
					mw = gpc_merge({24'h0, st.ctrl2}, pwdata, pstrb);
					next_st.ctrl2 = {mw[7:1], 1'b0};
				end
				default: mw = 32'h0;
			endcase
		end

		if (!gen_en)
		begin
			next_st.gph = GPC_GATE_HIGH;
			next_st.gcnt = 5'h0;
		end
		else if (gtick)
		begin
			case (st.gph)
				GPC_GATE_HIGH:
				begin
					lim = GATE_LEN - {1'b0, st.gate_set[GS_TA +: 4]};
					if (gnext >= lim)
						next_st.gph = GPC_GATE_LOW;
				end
				GPC_GATE_LOW:
				begin
					lim = GATE_LEN - {1'b0, st.gate_set[GS_TB +: 4]};
					if (gnext >= lim)
						next_st.gph = GPC_GATE_HIGH;
				end
				default: next_st.gph = GPC_GATE_HIGH;
			endcase
			next_st.gcnt = (gnext >= lim) ? 5'h0 : gnext;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.ctrl1 <= CTRL1_RST;
			st.ctrl2 <= CTRL2_RST;
			st.gate_set <= GATE_RST;
			st.cfg <= CFG_RST;
			st.cmp <= CMP_RST;
			st.gph <= GPC_GATE_HIGH;
			st.aux_drv <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign pready = 1'b1;
	assign prdata = st.rdata;
	assign pslverr = st.slverr;
	assign aux_pin_out = st.aux_out;
	assign aux_pin_drive = st.aux_drv;
	assign counter_interrupt = st.irq;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ovf_wrap: assert property (
		running && cnt_tick && st.cnt == CNT_MAX && !clear_req
		|=> st.ovf && st.cnt == 18'h0)
		else $error("wrap did not set overflow");
	a_ovf_hold: assert property (
		st.ovf && running && !clear_req |=> st.ovf)
		else $error("overflow flag dropped without clear");
	a_match_clear: assert property (
		running && mode == MODE_TE && cnt_tick && match && !clear_req
		|=> st.cnt == 18'h0 && counter_interrupt)
		else $error("compare match did not clear and interrupt");
	a_event_step: assert property (
		running && mode == MODE_TE && src == SRC_EXT &&
		sy_fall[SY_ECI] && !match && !clear_req && st.cnt != CNT_MAX
		|=> st.cnt == $past(cplus))
		else $error("event edge did not advance counter");
	a_pulse_irq: assert property (
		running && mode == MODE_PWM && (sy_fall[SY_ECI] ||
		(st.ctrl2[C2_GATE_IRQ_EDGE_SELECT] && sy_rise[SY_ECI])) |=> counter_interrupt)
		else $error("pulse edge gave no interrupt");
	a_stop_irq: assert property (
		wr_c1 && running && pwdata[C1_RUN +: 2] == RUN_STOP &&
		pwdata[C1_MODE +: 2] == MODE_PWM && sy_lvl[SY_ECI]
		|=> counter_interrupt ##1 !running)
		else $error("stop while high gave no interrupt");
	a_start_irq: assert property (
		wr_c1 && pwdata[C1_RUN +: 2] == RUN_START &&
		pwdata[C1_MODE +: 2] == MODE_PWM && st.ctrl2[C2_GATE_IRQ_EDGE_SELECT] &&
		sy_lvl[SY_ECI] |=> counter_interrupt)
		else $error("dual-edge start while high gave no interrupt");
	a_status_bits: assert property (
		setup && paddr == {IDX_STAT, 2'h0}
		|=> prdata[5:0] == 6'h0 && prdata[ST_OVF] == $past(st.ovf))
		else $error("status read shows wrong low bits");
	a_active_flag: assert property (
		setup && paddr == {IDX_STAT, 2'h0} && !running
		|=> !prdata[ST_ACT])
		else $error("activity flag set while stopped");
	a_aux_gate: assert property (
		st.ctrl2[C2_AUXG] |=> !aux_pin_drive && !aux_pin_out)
		else $error("aux pin driven while suppressed");

	c_timer_match: cover property (running && mode == MODE_TE &&
		src != SRC_EXT && cnt_tick && match);
	c_overflow: cover property ($rose(st.ovf));
	c_pulse_irq: cover property (mode == MODE_PWM && counter_interrupt);
	c_gate_fall: cover property (running && mode == MODE_FREQ &&
		st.gate_q && !gate);
endmodule
`default_nettype wire

/* File: verif/gpc_pulse_src.sv */
// pulse source model driving the count input pin
`timescale 1ns/100ps
`default_nettype none
module gpc_pulse_src
(
	input wire logic pclk, // system clock
	input wire logic go, // start a burst
	input wire logic hold, // force the pin high
	input wire logic [7:0] n_pulses, // pulses per burst
	input wire logic [7:0] hi_len, // high width in cycles
	input wire logic [7:0] lo_len, // low width in cycles
	output logic pin, // count pin level
	output logic busy // burst in progress
);
	logic pulse;
	initial
	begin
		pulse = 1'b0;
		busy = 1'b0;
		forever
		begin
			@(posedge pclk);
			if (go)
			begin
				busy <= 1'b1;
				for (int i = 0; i < n_pulses; i++)
				begin
					pulse <= 1'b1;
					repeat (hi_len) @(posedge pclk);
					pulse <= 1'b0;
					repeat (lo_len) @(posedge pclk);
				end
				busy <= 1'b0;
			end
		end
	end
	// the pin is a driven push-pull line, low outside bursts unless hold is high
	assign pin = hold | pulse;
endmodule
`default_nettype wire

/* File: verif/gpc_top_tb.sv */
// self-checking bench for the gated pulse counter
`timescale 1ns/100ps
`default_nettype none
module gpc_top_tb;
	import gpc_pkg::*;
	typedef struct {
		string nm;
		logic [31:0] exp;
		logic [31:0] alt;
		logic err;
	} gpc_note_type;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic gate, auxt, aux_out, aux_drv, irq, go, hold, pin, busy;
	logic [7:0] np, hl, ll;
	gpc_note_type notes[$];
	gpc_note_type nt;
	int failures, cmp_count, irq_n, seed, n, k;
	gpc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.external_count_input(pin), .external_gate_input(gate),
		.fs_clock_level(1'b0), .aux_timer_output(auxt),
		.aux_pin_out(aux_out), .aux_pin_drive(aux_drv),
		.counter_interrupt(irq));
	gpc_pulse_src i_src (.pclk(pclk), .go(go), .hold(hold), .n_pulses(np),
		.hi_len(hl), .lo_len(ll), .pin(pin), .busy(busy));
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	function logic [7:0] ad(input logic [5:0] i);
		return {i, 2'b00};
	endfunction
	function logic [31:0] c1(input logic c, input logic [1:0] r,
		input logic [2:0] s, input logic [1:0] m);
		return {24'h0, c, r, s, m};
	endfunction
	// the request stands until pready is seen high at a rising edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			t++;
		end
		while (pready !== 1'b1 && t < 50);
		if (t >= 50)
		begin
			failures++;
			print_verdict;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [5:0] i, input logic [31:0] d);
		xfer(1'b1, ad(i), d);
	endtask
	task rd(input string nm, input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] alt, input logic err);
		notes.push_back('{nm, e, alt, err});
		xfer(1'b0, a, 32'h0);
	endtask
	task wait_irq(input int lim);
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (irq !== 1'b1 && n < lim);
		if (n >= lim)
		begin
			failures++;
			print_verdict;
		end
	endtask
	task burst(input int cnt, input int hi, input int lo);
		int t;
		t = 0;
		@(posedge pclk);
		np <= 8'(cnt);
		hl <= 8'(hi);
		ll <= 8'(lo);
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		do
		begin
			@(posedge pclk);
			t++;
		end
		while (busy !== 1'b0 && t < 5000);
		if (t >= 5000)
		begin
			failures++;
			print_verdict;
		end
	endtask
	task irq_after(input string nm, input int base, input int want);
		repeat (6) @(posedge pclk);
		chk(nm, want, irq_n - base);
	endtask
	// read results are judged in the access cycle, oldest note first
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite)
		begin
			if (notes.size() == 0)
				chk("unexpected read", 32'h1, 32'h0);
			else
			begin
				nt = notes.pop_front();
				chk(nt.nm, (prdata === nt.alt) ? nt.alt : nt.exp, prdata);
				chk({nt.nm, " error"}, {31'h0, nt.err}, {31'h0, pslverr});
			end
		end
	always @(posedge pclk)
		if (irq === 1'b1)
			irq_n <= irq_n + 1;
	initial
	begin
		failures = 0;
		cmp_count = 0;
		irq_n = 0;
		seed = 32'h893e;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		gate = 1'b0;
		auxt = 1'b0;
		go = 1'b0;
		hold = 1'b0;
		np = 8'h00;
		hl = 8'h04;
		ll = 8'h04;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd("ctrl1 reset", ad(IDX_CTRL1), 32'h88, 32'h88, 1'b0);
		rd("ctrl2 reset", ad(IDX_CTRL2), 32'h00, 32'h00, 1'b0);
		rd("status reset", ad(IDX_STAT), 32'h00, 32'h00, 1'b0);
		rd("counter reset", ad(IDX_CMP), 32'h0, 32'h0, 1'b0);
		wr(IDX_CTRL2, 32'h5e);
		rd("ctrl2 back", ad(IDX_CTRL2), 32'h5e, 32'h5e, 1'b0);
		auxt <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("aux drive off", 32'h0, {31'h0, aux_drv});
		wr(IDX_CTRL2, 32'h00);
		repeat (3) @(posedge pclk);
		chk("aux drive on", 32'h1, {31'h0, aux_drv});
		chk("aux out", 32'h1, {31'h0, aux_out});
		rd("unmapped", 8'h5c, 32'h0, 32'h0, 1'b1);
		rd("misaligned", 8'h41, 32'h0, 32'h0, 1'b1);
		wr(IDX_STAT, 32'hff);
		rd("status ro", ad(IDX_STAT), 32'h00, 32'h00, 1'b0);
		$display("test registers done");
		wr(IDX_CMP, 32'h3);
		wr(IDX_CTRL1, c1(1'b1, RUN_STOP, SRC_FC, MODE_TE));
		wr(IDX_CTRL1, c1(1'b1, RUN_START, SRC_FC, MODE_TE));
		wait_irq(100);
		wait_irq(100);
		chk("timer period", 32'd6, n);
		wr(IDX_CTRL1, c1(1'b1, RUN_STOP, SRC_FC, MODE_TE));
		rd("stopped counter", ad(IDX_CMP), 32'h0, 32'h0, 1'b0);
		wr(IDX_CFG, 32'h2);
		wr(IDX_CMP, 32'h801);
		wr(IDX_CTRL1, c1(1'b1, RUN_START, SRC_FC, MODE_TE));
		wait_irq(5000);
		wait_irq(5000);
		chk("slow fc period", 32'd4096, n);
		wr(IDX_CTRL1, c1(1'b1, RUN_STOP, SRC_FC, MODE_TE));
		wr(IDX_CFG, 32'h0);
		$display("test timer done");
		wr(IDX_CMP, 32'h5);
		wr(IDX_CTRL1, c1(1'b1, RUN_STOP, SRC_EXT, MODE_TE));
		wr(IDX_CTRL1, c1(1'b1, RUN_START, SRC_EXT, MODE_TE));
		k = irq_n;
		burst(7, 4 + ($unsigned($random(seed)) % 8), 12);
		chk("event irqs", 32'd1, irq_n - k);
		rd("event count", ad(IDX_CMP), 32'd2, 32'd2, 1'b0);
		rd("misaligned live", 8'h42, 32'h0, 32'h0, 1'b1);
		wr(IDX_CTRL1, c1(1'b0, RUN_START, SRC_EXT, MODE_TE));
		rd("cleared count", ad(IDX_CMP), 32'd0, 32'd0, 1'b0);
		wr(IDX_CTRL1, c1(1'b1, RUN_STOP, SRC_EXT, MODE_TE));
		$display("test event done");
		wr(IDX_CTRL1, c1(1'b1, RUN_STOP, SRC_EXT, MODE_FREQ));
		wr(IDX_CTRL2, 32'h80);
		gate <= 1'b1;
		wr(IDX_CTRL1, c1(1'b1, RUN_START, SRC_EXT, MODE_FREQ));
		burst(7, 4 + ($unsigned($random(seed)) % 8), 12);
		rd("both edge count", ad(IDX_CMP), 32'd14, 32'd14, 1'b0);
		rd("active status", ad(IDX_STAT), 32'h80, 32'h80, 1'b0);
		k = irq_n;
		gate <= 1'b0;
		irq_after("gate fall irq", k, 1);
		rd("idle status", ad(IDX_STAT), 32'h00, 32'h00, 1'b0);
		wr(IDX_CTRL1, c1(1'b1, RUN_STOP, SRC_EXT, MODE_FREQ));
		$display("test frequency done");
		wr(IDX_CTRL1, c1(1'b1, RUN_STOP, SRC_FC, MODE_PWM));
		wr(IDX_CTRL2, 32'h00);
		wr(IDX_CTRL1, c1(1'b1, RUN_START, SRC_FC, MODE_PWM));
		k = irq_n;
		burst(1, 40, 12);
		chk("pulse irqs", 32'd1, irq_n - k);
		rd("pulse width", ad(IDX_CMP), 32'd20, 32'd21, 1'b0);
		rd("pulse status", ad(IDX_STAT), 32'h00, 32'h80, 1'b0);
		wr(IDX_CTRL1, c1(1'b1, RUN_STOP, SRC_FC, MODE_PWM));
		wr(IDX_CTRL2, 32'h10);
		hold <= 1'b1;
		repeat (6) @(posedge pclk);
		k = irq_n;
		wr(IDX_CTRL1, c1(1'b1, RUN_START, SRC_FC, MODE_PWM));
		irq_after("start high irq", k, 1);
		k = irq_n;
		wr(IDX_CTRL1, c1(1'b1, RUN_STOP, SRC_FC, MODE_PWM));
		irq_after("stop high irq", k, 1);
		hold <= 1'b0;
		$display("test pulse width done");
		// internal gate one tick high, one tick low
		wr(IDX_GATE, 32'hff);
		wr(IDX_CTRL2, 32'h20);
		wr(IDX_CTRL1, c1(1'b1, RUN_STOP, SRC_EXT, MODE_FREQ));
		wr(IDX_CTRL1, c1(1'b1, RUN_START, SRC_EXT, MODE_FREQ));
		wait_irq(9000);
		wait_irq(9000);
		chk("gate period", 2 * (1 << GTAP_FC), n);
		wr(IDX_CTRL1, c1(1'b1, RUN_STOP, SRC_EXT, MODE_FREQ));
		$display("test gate generator done");
		print_verdict;
	end
endmodule
`default_nettype wire
